//--- core/ppm_pkg.sv
// Purpose: Constants shared by the peripheral pin multiplexer.
// Assumes: Eight shared lines, one select code per line.
// Notes: Line numbers give the bit of each pin inside the 8-bit vectors.
`default_nettype none
package ppm_pkg;
    localparam int PPM_LINES = 8;
    // --------------------------------
    // Line index of each shared pin
    // --------------------------------
    localparam int LINE_DMA_READY = 0;
    localparam int LINE_UART_TX = 1;
    localparam int LINE_UART_RX = 2;
    localparam int LINE_SER_IN = 3;
    localparam int LINE_SER_SEL = 4;
    localparam int LINE_SER_CLK = 5;
    localparam int LINE_SER_OUT = 6;
    localparam int LINE_BOOT_CS = 7;
    // --------------------------------
    // Reset values
    // --------------------------------
    // Boot select, serial out, clock and select are outputs; others inputs
    localparam logic [7:0] DIR_RESET = 8'hf0;
    localparam logic [7:0] DATA_RESET = 8'h10;
    localparam logic [7:0] GP_SEL_RESET = 8'h00;
    // --------------------------------
    // Function modes
    // --------------------------------
    typedef enum logic [1:0] {
        PPM_FN_PERIPH = 2'h0,
        PPM_FN_GPIO = 2'h1,
        PPM_FN_ALT2 = 2'h2
    } ppm_fn_t;
endpackage : ppm_pkg
`default_nettype wire

//--- core/ppm_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin inputs.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: First stage is read only by the second.
`default_nettype none
module ppm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : ppm_sync
`default_nettype wire

//--- core/ppm_pin_mux.sv
// Purpose: Pin multiplexer for eight general-purpose lines shared with peripherals.
// Assumes: Pad inputs asynchronous; peripheral signals on sys_clk.
// Notes: Output enable high while the device drives a pad.
//
// Behaviour
// - Each of eight general lines is software-set as input or output.
// - General lines share boot select, serial, UART and DMA ready pins.
// - After reset boot select, serial out, clock, select are outputs; rest inputs.
// - Ready mode: low on DMA input starts next datum in the frame.
// - Done mode: low on the same DMA input ends the current frame.
// - DMA pin is line 0 first alternate, done input second alternate.
// - UART receive doubles as line 2, UART transmit as line 1.
// - Serial output drives chip data input; doubles as line 6 and boot data out.
// - Satellite boot reads PCI configuration over serial out, in and clock.
// - Serial input receives data, input after reset, line 3 and boot data in.
// - In serial mode the serial clock pin is a device output.
// - Serial clock doubles as line 5 and the boot ROM clock.
// - Serial select picks the serial chip, doubles as line 4.
// - In satellite mode grant 1 pin is the boot ROM chip select.
// - In host mode grant 1 pin is only general line 7.
`default_nettype none
module ppm_pin_mux
    import ppm_pkg::*;
#(
    parameter int LINES = PPM_LINES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Software controls
    input wire logic [LINES-1:0] gp_sel,
    input wire logic [LINES-1:0] gp_dir_wr,
    input wire logic [LINES-1:0] gp_dir_wdata,
    input wire logic [LINES-1:0] gp_data_wr,
    input wire logic [LINES-1:0] gp_data_wdata,
    input wire logic dma_done_mode,
    input wire logic satellite_mode,
    input wire logic boot_load,
    output logic [LINES-1:0] gp_dir,
    output logic [LINES-1:0] gp_in,
    // Pads
    input wire logic [LINES-1:0] pad_in,
    output logic [LINES-1:0] pad_out,
    output logic [LINES-1:0] pad_oe,
    // Serial port engine
    input wire logic ser_out,
    input wire logic ser_clk,
    input wire logic ser_sel_n,
    output logic ser_in,
    // Boot ROM loader
    input wire logic boot_rom_data_out,
    input wire logic boot_rom_clock,
    input wire logic boot_rom_cs,
    output logic boot_rom_data_in,
    // UART
    input wire logic uart_tx,
    output logic uart_rx,
    // DMA channel 0
    output logic dma_next_datum,
    output logic dma_end_frame
);
    // --------------------------------
    // Registers
    // --------------------------------
    logic [LINES-1:0] dir_reg;
    logic [LINES-1:0] data_reg;
    logic [LINES-1:0] dir_next;
    logic [LINES-1:0] data_next;
    logic [LINES-1:0] pin_sync;
    logic dma_prev_reg;
    logic [LINES-1:0] out_reg;
    logic [LINES-1:0] oe_reg;
    logic ser_in_reg;
    logic boot_in_reg;
    logic uart_rx_reg;
    logic next_reg;
    logic end_reg;

    // Per-bit write merge, used for both direction and data
    function automatic logic [LINES-1:0] merge(
        input logic [LINES-1:0] old_v,
        input logic [LINES-1:0] wr,
        input logic [LINES-1:0] wd
    );
        merge = (old_v & ~wr) | (wd & wr);
    endfunction : merge

    assign dir_next = merge(dir_reg, gp_dir_wr, gp_dir_wdata);
    assign data_next = merge(data_reg, gp_data_wr, gp_data_wdata);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dir_reg <= DIR_RESET;
            data_reg <= DATA_RESET;
        end else if (clk_en) begin
            dir_reg <= dir_next;
            data_reg <= data_next;
        end
    end

    // --------------------------------
    // Pad input synchroniser
    // --------------------------------
    ppm_sync #(
        .WIDTH(LINES)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(pad_in),
        .sync_out(pin_sync)
    );

    // --------------------------------
    // Peripheral drive per line
    // --------------------------------
    // Boot loader owns serial pins only in satellite boot
    wire boot_act = satellite_mode & boot_load;
    wire [LINES-1:0] per_out;
    wire [LINES-1:0] per_oe;

    assign per_out[LINE_DMA_READY] = 1'b0;
    assign per_oe[LINE_DMA_READY] = 1'b0;
    // UART transmit drives only once software made the line an output
    assign per_out[LINE_UART_TX] = uart_tx;
    assign per_oe[LINE_UART_TX] = dir_reg[LINE_UART_TX];
    assign per_out[LINE_UART_RX] = 1'b0;
    assign per_oe[LINE_UART_RX] = 1'b0;
    assign per_out[LINE_SER_IN] = 1'b0;
    assign per_oe[LINE_SER_IN] = 1'b0;
    assign per_out[LINE_SER_SEL] = boot_act ? 1'b1 : ser_sel_n;
    assign per_oe[LINE_SER_SEL] = 1'b1;
    assign per_out[LINE_SER_CLK] = boot_act ? boot_rom_clock : ser_clk;
    assign per_oe[LINE_SER_CLK] = 1'b1;
    assign per_out[LINE_SER_OUT] = boot_act ? boot_rom_data_out : ser_out;
    assign per_oe[LINE_SER_OUT] = 1'b1;
    // Grant 1 is never a grant; chip select only in satellite mode
    assign per_out[LINE_BOOT_CS] = boot_rom_cs;
    assign per_oe[LINE_BOOT_CS] = satellite_mode;

    // --------------------------------
    // Final selection
    // --------------------------------
    // Host mode forces grant 1 into general mode
    wire [LINES-1:0] gp_mode = gp_sel
        | ({{(LINES-1){1'b0}}, ~satellite_mode} << LINE_BOOT_CS);
    wire [LINES-1:0] out_next = (gp_mode & data_reg) | (~gp_mode & per_out);
    wire [LINES-1:0] oe_next = (gp_mode & dir_reg) | (~gp_mode & per_oe);

    // Registered pads: a mode change cannot glitch a pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_reg <= DATA_RESET;
            oe_reg <= DIR_RESET;
        end else if (clk_en) begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign pad_out = out_reg;
    assign pad_oe = oe_reg;
    assign gp_dir = dir_reg;
    assign gp_in = pin_sync;

    // --------------------------------
    // Inputs towards peripherals
    // --------------------------------
    // DMA and UART receive see idle high while their pin is taken for general use
    wire dma_low = ~gp_mode[LINE_DMA_READY] & ~pin_sync[LINE_DMA_READY];
    wire dma_fall = dma_low & ~dma_prev_reg;

    // --------------------------------
    // DMA channel 0 edge detect
    // --------------------------------
    // Previous level starts as active so the cleared synchroniser
    // gives no false edge straight after reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dma_prev_reg <= 1'b1;
            next_reg <= 1'b0;
            end_reg <= 1'b0;
        end else if (clk_en) begin
            dma_prev_reg <= dma_low;
            next_reg <= dma_fall & ~dma_done_mode;
            end_reg <= dma_fall & dma_done_mode;
        end
    end

    // --------------------------------
    // Serial input steering
    // --------------------------------
    // Only one receiver sees the pin; the other reads low
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ser_in_reg <= 1'b0;
            boot_in_reg <= 1'b0;
        end else if (clk_en) begin
            ser_in_reg <= ~boot_act & pin_sync[LINE_SER_IN];
            boot_in_reg <= boot_act & pin_sync[LINE_SER_IN];
        end
    end

    // --------------------------------
    // UART receive
    // --------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            uart_rx_reg <= 1'b1;
        end else if (clk_en) begin
            uart_rx_reg <= gp_mode[LINE_UART_RX] | pin_sync[LINE_UART_RX];
        end
    end

    assign dma_next_datum = next_reg;
    assign dma_end_frame = end_reg;
    assign ser_in = ser_in_reg;
    assign boot_rom_data_in = boot_in_reg;
    assign uart_rx = uart_rx_reg;
endmodule : ppm_pin_mux
`default_nettype wire

//--- sim/ppm_pin_mux_monitor.sv
// Purpose: Port checks for the pin multiplexer.
// Assumes: Mux outputs lag their inputs by one edge.
// Notes: Sees only top ports.
`default_nettype none
module ppm_pin_mux_chk
    import ppm_pkg::*;
#(
    parameter int LINES = PPM_LINES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [LINES-1:0] gp_sel,
    input wire logic [LINES-1:0] gp_dir,
    input wire logic [LINES-1:0] pad_out,
    input wire logic [LINES-1:0] pad_oe,
    input wire logic ser_out,
    input wire logic ser_clk,
    input wire logic ser_sel_n,
    input wire logic boot_rom_clock,
    input wire logic boot_rom_cs,
    input wire logic satellite_mode,
    input wire logic boot_load,
    input wire logic dma_next_datum,
    input wire logic dma_end_frame
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic boot = satellite_mode && boot_load;
    // ----------
    // Checks
    // ----------
    a_reset_dirs: assert property ($fell(reset) |-> gp_dir == DIR_RESET)
        else $error("reset direction");
    a_gen_oe: assert property (clk_en && (&gp_sel) |=> pad_oe == $past(gp_dir))
        else $error("general enable");
    a_ser_pins: assert property (clk_en && gp_sel[6:4] == 3'h0 && !boot
        |=> pad_oe[6:4] == 3'h7 && pad_out[6:4] == $past({ser_out, ser_clk, ser_sel_n}))
        else $error("serial pins");
    a_boot_pins: assert property (clk_en && boot && gp_sel[5:4] == 2'h0
        |=> pad_out[5:4] == {$past(boot_rom_clock), 1'b1}) else $error("boot pins");
    a_boot_cs: assert property (clk_en && satellite_mode && !gp_sel[7] |=> pad_oe[7]
        && pad_out[7] == $past(boot_rom_cs)) else $error("boot select");
    a_host_gp7: assert property (clk_en && !satellite_mode
        |=> pad_oe[7] == $past(gp_dir[7])) else $error("host line 7");
    a_tx_gate: assert property (clk_en && !gp_sel[1]
        |=> pad_oe[1] == $past(gp_dir[1])) else $error("uart tx gate");
    a_dma_pulse: assert property (clk_en && (dma_next_datum || dma_end_frame)
        |=> !dma_next_datum && !dma_end_frame) else $error("dma pulse");
    a_hold_frozen: assert property (!clk_en
        |=> $stable(pad_oe) && $stable(pad_out) && $stable(gp_dir)) else $error("freeze");
endmodule : ppm_pin_mux_chk
bind ppm_pin_mux ppm_pin_mux_chk #(.LINES(LINES)) u_chk (.sys_clk, .reset, .clk_en, .gp_sel, .gp_dir,
    .pad_out, .pad_oe, .ser_out, .ser_clk, .ser_sel_n, .boot_rom_clock, .boot_rom_cs,
    .satellite_mode, .boot_load, .dma_next_datum, .dma_end_frame);
`default_nettype wire

//--- sim/ppm_far_side.sv
// Purpose: Serial chip, UART line and DMA requester.
// Assumes: Pull-ups on lines 1 and 7.
// Notes: Serial chip echoes serial out while selected.
`default_nettype none
module ppm_far_side (
    input wire logic sys_clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic uart_line,
    input wire logic dma_n,
    output logic [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic miso_reg = 1'b0;
    logic tog_reg = 1'b0;
    wire logic sel = pad_oe[4] && (!pad_out[4] || pad_out[7]);
    wire logic [7:0] ext = {1'b1, {3{tog_reg}}, miso_reg, uart_line, 1'b1, dma_n};
    // Undriven lines 4 to 6, and line 3 while deselected, toggle so stale values never pass
    always @(posedge sys_clk) begin
        tog_reg <= !tog_reg;
        miso_reg <= sel ? pad_out[6] : !miso_reg;
    end
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule : ppm_far_side
`default_nettype wire

//--- sim/ppm_pin_mux_test.sv
// Purpose: Directed test of the pin multiplexer.
// Assumes: clk_en high except in the freeze test.
// Notes: Checks sample 1 ns after an edge.
`default_nettype none
module ppm_pin_mux_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] gp_sel = 8'h00, gp_dir_wr = 8'h00, gp_dir_wdata = 8'h00;
    logic [7:0] gp_data_wr = 8'h00, gp_data_wdata = 8'h00;
    logic dma_done_mode = 1'b0, satellite_mode = 1'b0, boot_load = 1'b0, ser_out = 1'b0;
    logic ser_clk = 1'b0, ser_sel_n = 1'b1, boot_rom_data_out = 1'b0, boot_rom_clock = 1'b0;
    logic boot_rom_cs = 1'b0, uart_tx = 1'b0, uart_line = 1'b1, dma_n = 1'b1;
    logic [7:0] gp_dir, gp_in, pad_in, pad_out, pad_oe;
    logic ser_in, boot_rom_data_in, uart_rx, dma_next_datum, dma_end_frame;
    int errors = 0, total_checks = 0, n_nxt = 0, n_eof = 0;
    ppm_pin_mux DUT (.sys_clk, .reset, .clk_en, .gp_sel, .gp_dir_wr, .gp_dir_wdata,
        .gp_data_wr, .gp_data_wdata, .dma_done_mode, .satellite_mode, .boot_load, .gp_dir,
        .gp_in, .pad_in, .pad_out, .pad_oe, .ser_out, .ser_clk, .ser_sel_n, .ser_in,
        .boot_rom_data_out, .boot_rom_clock, .boot_rom_cs, .boot_rom_data_in, .uart_tx,
        .uart_rx, .dma_next_datum, .dma_end_frame);
    ppm_far_side u_far (.sys_clk, .pad_out, .pad_oe, .uart_line, .dma_n, .pad_in);
    initial forever #12.5 sys_clk = !sys_clk;
    always @(posedge sys_clk) begin
        n_nxt <= n_nxt + (dma_next_datum === 1'b1);
        n_eof <= n_eof + (dma_end_frame === 1'b1);
    end
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] m, input logic [7:0] dv, input logic [7:0] ov);
        @(posedge sys_clk);
        gp_dir_wr <= m;
        gp_dir_wdata <= dv;
        gp_data_wr <= m;
        gp_data_wdata <= ov;
        @(posedge sys_clk);
        gp_dir_wr <= 8'h00;
        gp_data_wr <= 8'h00;
    endtask : wr
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Tests need about 90 cycles
    initial begin
        #50000;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        step(0);
        chk(gp_dir, ppm_pkg::DIR_RESET);
        chk(pad_oe, 8'hf0);
        chk(pad_out, ppm_pkg::DATA_RESET);
        @(posedge sys_clk);
        {ser_out, ser_clk, ser_sel_n, uart_line, uart_tx} <= 5'h19;
        step(2);
        chk(pad_out & 8'h70, 8'h60);
        chk(pad_oe, 8'hf0);
        step(6);
        chk(ser_in, 8'h01);
        chk(uart_rx, 8'h00);
        wr(8'h02, 8'h02, 8'h00);
        step(2);
        chk({pad_oe[1], pad_out[1]}, 8'h03);
        @(posedge sys_clk);
        gp_sel <= 8'hff;
        wr(8'hff, 8'h5a, 8'h3c);
        step(4);
        chk(pad_oe, 8'h5a);
        chk(pad_out & 8'h5a, 8'h18);
        chk(gp_in & 8'h5a, 8'h18);
        @(posedge sys_clk);
        gp_sel <= 8'h00;
        {satellite_mode, boot_load, boot_rom_data_out, boot_rom_cs} <= 4'hf;
        step(2);
        chk(pad_out & 8'hf0, 8'hd0);
        chk(pad_oe & 8'hf0, 8'hf0);
        step(6);
        chk(boot_rom_data_in, 8'h01);
        @(posedge sys_clk);
        {satellite_mode, boot_load} <= 2'h0;
        step(2);
        chk(pad_oe[7], 8'h00);
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk);
            dma_done_mode <= (m == 1);
            gp_sel <= (m == 2) ? 8'h01 : 8'h00;
            dma_n <= 1'b0;
            step(6);
            @(posedge sys_clk);
            dma_n <= 1'b1;
            step(6);
            chk(n_nxt, 8'h01);
            chk(n_eof, (m > 0) ? 8'h01 : 8'h00);
        end
        // Frozen: serial levels must not reach the pads, nor a write the direction register
        @(posedge sys_clk);
        clk_en <= 1'b0;
        {ser_out, ser_clk} <= 2'h0;
        wr(8'h80, 8'h80, 8'h80);
        step(2);
        chk(pad_out & 8'h70, 8'h60);
        chk(gp_dir, 8'h5a);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        step(3);
        chk(pad_out & 8'h70, 8'h00);
        chk(gp_dir, 8'h5a);
        tally_and_finish();
    end
endmodule : ppm_pin_mux_test
`default_nettype wire
